// ==== design/cse_pkg.sv ====
/*
 * Shared constants, register map and carrier types of the per-socket
 * status-change event block.
 * Assumes one 10 MHz clock; the requester of the register port and the
 * configuration port runs on that clock.
 */
// Contract
// - socket registers located by config BAR 10h
// - five 32-bit socket registers, others reserved
// - event says change occurred; read live status
// - writing one clears event bit, zero keeps
// - injection write sets matching event bit
// - host reset clears events; may re-set after
// - sticky bits survive host reset under PME
// - interrupt when any enabled event set
// - event 3 on power-cycle status change
// - events 2/1 on detect two/one change
// - event 0 rising (CardBus) or both edges
// - bits 31..4 read zero, ignore writes
// - enables gate interrupt only, not events
// - enable bit 3 gates power events, reset 0
// - detect enable field 00 blocks, 11 allows
// - enable bit 0 gates status events, reset 0
// - detect two mirrors pin, frozen during interrogation
// - powered status 0 down, 1 up
`default_nettype none

package cse_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  CFG_BAR_OFS   = 8'h10;
    localparam int unsigned WINDOW_BITS   = 12;
    localparam logic [19:0] BAR_RST       = 20'h00000;
    localparam logic [11:0] OFS_EVENTS    = 12'h000;
    localparam logic [11:0] OFS_ENABLES   = 12'h004;
    localparam logic [11:0] OFS_LIVE      = 12'h008;
    localparam logic [11:0] OFS_INJECT    = 12'h00C;
    localparam logic [11:0] OFS_CONTROL   = 12'h010;

    // ------------------------------------------------------------
    // field layout (events, enables and live share bits 3..0)
    // ------------------------------------------------------------
    localparam int unsigned EVT_W         = 4;
    localparam int unsigned BIT_POWER     = 3;
    localparam int unsigned BIT_DET_TWO   = 2;
    localparam int unsigned BIT_DET_ONE   = 1;
    localparam int unsigned BIT_STATUS    = 0;
    localparam int unsigned LIVE_16BIT    = 4;
    localparam int unsigned LIVE_CARDBUS  = 5;
    localparam int unsigned LIVE_SOCK_5V  = 28;
    localparam int unsigned LIVE_SOCK_3V  = 29;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [3:0]  EVENTS_RST    = 4'h0;
    localparam logic [3:0]  ENABLES_RST   = 4'h0;
    // live order {powered, detect two, detect one, status line}
    localparam logic [3:0]  LIVE_IDLE     = 4'h6;
    // sync order {host reset_n, detect two_n, detect one_n, status}
    localparam logic [3:0]  SYNC_RST      = 4'h6;
    localparam int unsigned SYNC_W        = 4;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } cse_mem_req_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  offset;
        logic [31:0] wdata;
    } cse_cfg_req_type;

    typedef struct packed {
        logic        detect_two_n;
        logic        detect_one_n;
        logic        status_line;
    } cse_card_pins_type;

endpackage

`default_nettype wire

// ==== design/cse_sync.sv ====
/*
 * Two-stage synchroniser for the socket pins and the host bus reset.
 * Assumes the inputs are asynchronous to CLK and held for several cycles.
 */
`default_nettype none

module cse_sync (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic [cse_pkg::SYNC_W-1:0] async_in,
    output logic      [cse_pkg::SYNC_W-1:0] sync_out
);

    typedef struct packed {
        logic [cse_pkg::SYNC_W-1:0] meta;
        logic [cse_pkg::SYNC_W-1:0] stable;
    } cse_sync_state_type;

    cse_sync_state_type s_q;
    cse_sync_state_type s_d;

    // the first stage feeds only the second
    always_comb begin
        s_d.meta   = async_in;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= {cse_pkg::SYNC_RST, cse_pkg::SYNC_RST};
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.stable;

endmodule

`default_nettype wire

// ==== design/cse_change_det.sv ====
/*
 * Per-bit rise and fall detector for the socket live status.
 * Assumes the level is already on CLK; clear reloads the idle state.
 */
`default_nettype none

module cse_change_det (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     clear,
    input  wire logic [cse_pkg::EVT_W-1:0] level,
    output logic      [cse_pkg::EVT_W-1:0] rise,
    output logic      [cse_pkg::EVT_W-1:0] fall
);

    typedef struct packed {
        logic [cse_pkg::EVT_W-1:0] prev;
    } cse_det_state_type;

    cse_det_state_type s_q;
    cse_det_state_type s_d;

    // reloading idle makes a still-present card re-fire after reset
    always_comb begin
        s_d.prev = clear ? cse_pkg::LIVE_IDLE : level;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= cse_pkg::LIVE_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    for (genvar i = 0; i < cse_pkg::EVT_W; i++) begin : g_edge
        assign rise[i] = level[i] & ~s_q.prev[i];
        assign fall[i] = ~level[i] & s_q.prev[i];
    end

endmodule

`default_nettype wire

// ==== design/cse_socket_events.sv ====
/*
 * Socket status-change event block: base address decode, event,
 * interrupt-enable, live-status and event-injection registers, and
 * the status-change interrupt of one card socket.
 * Assumes a memory register port and a configuration port that issue
 * one-cycle requests on CLK, socket pins asynchronous to CLK, and
 * power and card-type levels that already run on CLK.
 */
`default_nettype none

module cse_socket_events (
    input  wire logic                       CLK,
    input  wire logic                       RST,
    input  wire logic                       HOST_BUS_RESET_PIN_N,
    input  wire logic                       PME_ENABLE,
    input  wire cse_pkg::cse_cfg_req_type   CFG_REQ,
    output logic      [31:0]                CFG_RDATA,
    output logic                            CFG_ACK,
    input  wire cse_pkg::cse_mem_req_type   MEM_REQ,
    output logic      [31:0]                MEM_RDATA,
    output logic                            MEM_ACK,
    input  wire cse_pkg::cse_card_pins_type CARD_PINS,
    input  wire logic                       SOCKET_POWERED,
    input  wire logic                       CARDBUS_CARD,
    input  wire logic                       CARD_INTERROGATION,
    output logic                            STATUS_CHANGE_INTERRUPT
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [19:0] bar;
        logic [3:0]  events;
        logic [3:0]  enables;
        logic [3:0]  live;
        logic [31:0] mem_rdata;
        logic        mem_ack;
        logic [31:0] cfg_rdata;
        logic        cfg_ack;
        logic        irq;
    } cse_core_state_type;

    localparam cse_core_state_type STATE_RST = '{
        bar:       cse_pkg::BAR_RST,
        events:    cse_pkg::EVENTS_RST,
        enables:   cse_pkg::ENABLES_RST,
        live:      cse_pkg::LIVE_IDLE,
        mem_rdata: 32'h00000000,
        mem_ack:   1'b0,
        cfg_rdata: 32'h00000000,
        cfg_ack:   1'b0,
        irq:       1'b0
    };

    cse_core_state_type s_q;
    cse_core_state_type s_d;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // true when the request addresses the given register of the set
    function automatic logic reg_hit(
        input cse_pkg::cse_mem_req_type req,
        input logic [19:0]              bar,
        input logic [11:0]              ofs
    );
        logic in_window;
        in_window = (req.addr[31:cse_pkg::WINDOW_BITS] == bar)
                    && (bar != cse_pkg::BAR_RST);
        return in_window && (req.addr[11:2] == ofs[11:2]);
    endfunction

    // write strobe for the low byte, where every writable field sits
    function automatic logic low_write(
        input cse_pkg::cse_mem_req_type req,
        input logic [19:0]              bar,
        input logic [11:0]              ofs
    );
        return req.valid && req.write && req.be[0]
               && reg_hit(req, bar, ofs);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    logic [cse_pkg::SYNC_W-1:0] pins_async;
    logic [cse_pkg::SYNC_W-1:0] pins_sync;

    assign pins_async = {HOST_BUS_RESET_PIN_N,
                         CARD_PINS.detect_two_n,
                         CARD_PINS.detect_one_n,
                         CARD_PINS.status_line};

    cse_sync u_sync (
        .clk      (CLK),
        .rst      (RST),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    logic host_rst;
    logic det_two_s;
    logic det_one_s;
    logic status_s;

    assign host_rst  = ~pins_sync[3];
    assign det_two_s = pins_sync[2];
    assign det_one_s = pins_sync[1];
    assign status_s  = pins_sync[0];

    // ------------------------------------------------------------
    // change detection on the live status
    // ------------------------------------------------------------
    logic [3:0] rise;
    logic [3:0] fall;

    cse_change_det u_change (
        .clk   (CLK),
        .rst   (RST),
        .clear (host_rst),
        .level (s_q.live),
        .rise  (rise),
        .fall  (fall)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [3:0]  hw_set;
    logic [3:0]  inject;
    logic [3:0]  clear_ones;
    logic [3:0]  irq_gate;
    logic        card_present;
    logic        clear_sticky;
    logic        mem_take;
    logic [31:0] live_word;

    always_comb begin
        s_d         = s_q;
        s_d.mem_ack = 1'b0;
        s_d.cfg_ack = 1'b0;

        // live status: detect bits hold while the card is probed
        s_d.live[cse_pkg::BIT_POWER]  = SOCKET_POWERED;
        s_d.live[cse_pkg::BIT_STATUS] = status_s;
        if (!CARD_INTERROGATION) begin
            s_d.live[cse_pkg::BIT_DET_TWO] = det_two_s;
            s_d.live[cse_pkg::BIT_DET_ONE] = det_one_s;
        end

        // hardware event sources
        hw_set = 4'h0;
        hw_set[cse_pkg::BIT_POWER] =
            rise[cse_pkg::BIT_POWER] | fall[cse_pkg::BIT_POWER];
        hw_set[cse_pkg::BIT_DET_TWO] =
            rise[cse_pkg::BIT_DET_TWO]
            | fall[cse_pkg::BIT_DET_TWO];
        hw_set[cse_pkg::BIT_DET_ONE] =
            rise[cse_pkg::BIT_DET_ONE]
            | fall[cse_pkg::BIT_DET_ONE];
        if (CARDBUS_CARD) begin
            hw_set[cse_pkg::BIT_STATUS] =
                rise[cse_pkg::BIT_STATUS];
        end else begin
            hw_set[cse_pkg::BIT_STATUS] =
                rise[cse_pkg::BIT_STATUS]
                | fall[cse_pkg::BIT_STATUS];
        end

        // software writes; only bits 3..0 are taken, the rest dropped
        mem_take = MEM_REQ.valid && !host_rst;
        inject = 4'h0;
        clear_ones = 4'h0;
        if (mem_take && low_write(MEM_REQ, s_q.bar,
                                  cse_pkg::OFS_INJECT)) begin
            inject = MEM_REQ.wdata[3:0];
        end
        if (mem_take && low_write(MEM_REQ, s_q.bar,
                                  cse_pkg::OFS_EVENTS)) begin
            clear_ones = MEM_REQ.wdata[3:0];
        end
        if (mem_take && low_write(MEM_REQ, s_q.bar,
                                  cse_pkg::OFS_ENABLES)) begin
            s_d.enables = MEM_REQ.wdata[3:0];
        end

        // a set in the same cycle as its clear survives;
        // events are raised whatever the enables say
        s_d.events = hw_set | inject
                     | (s_q.events & ~clear_ones);

        // host reset is honoured for sticky bits only without PME
        clear_sticky = host_rst && !PME_ENABLE;
        if (clear_sticky) begin
            s_d.events  = cse_pkg::EVENTS_RST;
            s_d.enables = cse_pkg::ENABLES_RST;
        end
        if (host_rst) begin
            s_d.bar = cse_pkg::BAR_RST;
        end

        // interrupt gate: the detect pair counts only when both set,
        // so the undefined codes 01 and 10 block like 00
        irq_gate = 4'h0;
        irq_gate[cse_pkg::BIT_POWER] =
            s_d.enables[cse_pkg::BIT_POWER];
        irq_gate[cse_pkg::BIT_DET_TWO] =
            s_d.enables[cse_pkg::BIT_DET_TWO]
            & s_d.enables[cse_pkg::BIT_DET_ONE];
        irq_gate[cse_pkg::BIT_DET_ONE] =
            irq_gate[cse_pkg::BIT_DET_TWO];
        irq_gate[cse_pkg::BIT_STATUS] =
            s_d.enables[cse_pkg::BIT_STATUS];
        // stale events fire as soon as enabled; software clears first
        s_d.irq = |(s_d.events & irq_gate);

        // live status word as software sees it
        card_present = !s_q.live[cse_pkg::BIT_DET_ONE]
                       && !s_q.live[cse_pkg::BIT_DET_TWO];
        live_word = 32'h00000000;
        live_word[3:0] = s_q.live;
        live_word[cse_pkg::LIVE_CARDBUS] = card_present && CARDBUS_CARD;
        live_word[cse_pkg::LIVE_16BIT]   = card_present && !CARDBUS_CARD;
        live_word[cse_pkg::LIVE_SOCK_3V] = 1'b1;
        live_word[cse_pkg::LIVE_SOCK_5V] = 1'b1;

        // memory answer: any offset of the window is claimed,
        // reserved and write-only registers read as zero
        if (mem_take && reg_hit(MEM_REQ, s_q.bar,
                                MEM_REQ.addr[11:0])) begin
            s_d.mem_ack   = 1'b1;
            s_d.mem_rdata = 32'h00000000;
            if (!MEM_REQ.write) begin
                case (MEM_REQ.addr[11:0] & 12'hFFC)
                    cse_pkg::OFS_EVENTS: begin
                        s_d.mem_rdata = {28'h0000000, s_q.events};
                    end
                    cse_pkg::OFS_ENABLES: begin
                        s_d.mem_rdata = {28'h0000000, s_q.enables};
                    end
                    cse_pkg::OFS_LIVE: begin
                        s_d.mem_rdata = live_word;
                    end
                    default: begin
                        s_d.mem_rdata = 32'h00000000;
                    end
                endcase
            end
        end

        // configuration port: only the base address lives here
        if (CFG_REQ.valid && !host_rst) begin
            s_d.cfg_ack   = 1'b1;
            s_d.cfg_rdata = 32'h00000000;
            if (CFG_REQ.offset == cse_pkg::CFG_BAR_OFS) begin
                if (CFG_REQ.write) begin
                    s_d.bar = CFG_REQ.wdata[31:cse_pkg::WINDOW_BITS];
                end else begin
                    s_d.cfg_rdata = {s_q.bar, 12'h000};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign MEM_RDATA               = s_q.mem_rdata;
    assign MEM_ACK                 = s_q.mem_ack;
    assign CFG_RDATA               = s_q.cfg_rdata;
    assign CFG_ACK                 = s_q.cfg_ack;
    assign STATUS_CHANGE_INTERRUPT = s_q.irq;

endmodule

`default_nettype wire

// ==== bench/cse_socket_events_assertions.sv ====
/*
 * Port checker of the socket status-change event block.
 * Assumes a bind from the bench top and the single CLK domain.
 */
`default_nettype none

module cse_socket_events_chk (
    input wire logic                       CLK,
    input wire logic                       RST,
    input wire logic                       HOST_BUS_RESET_PIN_N,
    input wire logic                       PME_ENABLE,
    input wire cse_pkg::cse_cfg_req_type   CFG_REQ,
    input wire logic [31:0]                CFG_RDATA,
    input wire logic                       CFG_ACK,
    input wire cse_pkg::cse_mem_req_type   MEM_REQ,
    input wire logic [31:0]                MEM_RDATA,
    input wire logic                       MEM_ACK,
    input wire cse_pkg::cse_card_pins_type CARD_PINS,
    input wire logic                       SOCKET_POWERED,
    input wire logic                       CARDBUS_CARD,
    input wire logic                       CARD_INTERROGATION,
    input wire logic                       STATUS_CHANGE_INTERRUPT
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [2:0] up_q;
    logic [3:0] en_q;
    logic [3:0] pw_q;

    // enables are tracked at the request, so they stay permissive
    // across a host reset rather than guessing its clearing edge
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            up_q <= 3'h0;
            en_q <= 4'h0;
            pw_q <= 4'h0;
        end else begin
            up_q <= !HOST_BUS_RESET_PIN_N ? 3'h0 :
                    (up_q == 3'h7 ? up_q : up_q + 3'h1);
            pw_q <= {pw_q[2:0], SOCKET_POWERED};
            if (MEM_REQ.valid && MEM_REQ.write &&
                MEM_REQ.addr[11:0] == 12'h004) begin
                en_q <= MEM_REQ.wdata[3:0];
            end
        end
    end

    function automatic logic opens(input logic [3:0] e);
        return e[3] || (e[2] && e[1]) || e[0];
    endfunction

    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    // ------------------------------
    // assertions
    // ------------------------------
    AST_CFG_TAKE: assert property (
        CFG_REQ.valid && up_q == 3'h7 |=> CFG_ACK)
        else $error("config request left unanswered");
    AST_CFG_CAUSE: assert property (
        CFG_ACK |-> $past(CFG_REQ.valid))
        else $error("config answer without request");
    AST_BAR_LOW: assert property (
        CFG_ACK |-> CFG_RDATA[11:0] == 12'h000)
        else $error("base address low bits not zero");
    AST_MEM_CAUSE: assert property (
        MEM_ACK |-> $past(MEM_REQ.valid))
        else $error("memory answer without request");
    AST_WR_ZERO: assert property (
        MEM_ACK && $past(MEM_REQ.write) |-> MEM_RDATA == 32'h0)
        else $error("write answer carries data");
    AST_RSVD_ZERO: assert property (
        MEM_ACK && $past(MEM_REQ.addr[11:3]) == 9'h000
        |-> MEM_RDATA[31:4] == 28'h0)
        else $error("upper event or enable bits not zero");
    AST_OTHER_ZERO: assert property (
        MEM_ACK && $past(MEM_REQ.addr[11:0]) >= 12'h00C
        |-> MEM_RDATA == 32'h0)
        else $error("injection or reserved offset not zero");
    AST_LIVE_FIXED: assert property (
        MEM_ACK && $past(MEM_REQ.addr[11:0]) == 12'h008
        |-> MEM_RDATA[31:28] == 4'h3 && MEM_RDATA[27:6] == 22'h0)
        else $error("live status constant bits wrong");
    AST_LIVE_POWER: assert property (
        MEM_ACK && $past(MEM_REQ.addr[11:0]) == 12'h008 &&
        (pw_q == 4'h0 || pw_q == 4'hF) |-> MEM_RDATA[3] == pw_q[0])
        else $error("powered status does not follow socket");
    AST_IRQ_GATE: assert property (
        STATUS_CHANGE_INTERRUPT |-> opens(en_q) || opens($past(en_q)))
        else $error("interrupt raised with every source gated");

    COV_IRQ: cover property ($rose(STATUS_CHANGE_INTERRUPT));
    COV_ALL: cover property (MEM_ACK && MEM_RDATA[3:0] == 4'hF);
    COV_CFG: cover property (CFG_REQ.valid && up_q == 3'h7 ##1 CFG_ACK);
endmodule

`default_nettype wire

// ==== bench/cse_card_model.sv ====
/*
 * Behavioural card standing in one socket.
 * Assumes the bench commands insertion and the status line on clk.
 */
`default_nettype none

module cse_card_model (
    input  wire logic                      clk,
    input  wire logic                      inserted,
    input  wire logic                      status_high,
    output var  cse_pkg::cse_card_pins_type pins
);
    timeunit 1ns;
    timeprecision 1ns;

    initial pins = 3'b110;

    // contacts make one after the other, as on a real connector
    always @(posedge clk) begin
        pins.detect_one_n <= !inserted;
        pins.detect_two_n <= pins.detect_one_n;
        // line pulled low while no card drives it
        pins.status_line <= inserted && status_high;
    end
endmodule

`default_nettype wire

// ==== bench/tb_top.sv ====
/*
 * Self-checking bench of the socket event block with a card model.
 * Assumes the package, design, checker and card model compile first.
 */
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------
    // signals and reference state
    // ------------------------------
    localparam logic [31:0] BASE = 32'h0001_0000;
    logic clk, rst, hrst_n, pme, powered, cardbus, probe, ins, sts;
    logic irq, cack, mack, a;
    logic [31:0] crd, mrd, r;
    logic [15:0] lfsr;
    cse_pkg::cse_cfg_req_type   creq;
    cse_pkg::cse_mem_req_type   mreq;
    cse_pkg::cse_card_pins_type pins;
    int fail_count, n_tests, ev, en;

    cse_socket_events i_cse_socket_events (
        .CLK(clk), .RST(rst), .HOST_BUS_RESET_PIN_N(hrst_n),
        .PME_ENABLE(pme), .CFG_REQ(creq), .CFG_RDATA(crd),
        .CFG_ACK(cack), .MEM_REQ(mreq), .MEM_RDATA(mrd), .MEM_ACK(mack),
        .CARD_PINS(pins), .SOCKET_POWERED(powered),
        .CARDBUS_CARD(cardbus), .CARD_INTERROGATION(probe),
        .STATUS_CHANGE_INTERRUPT(irq));
    cse_card_model i_cse_card_model (.clk(clk), .inserted(ins),
        .status_high(sts), .pins(pins));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // requests are one-cycle pulses; the answer stands for one cycle
    task automatic mem(input logic w, input logic [31:0] ad,
                       input logic [31:0] d);
        @(posedge clk) mreq <= '{1'b1, w, ad, d, 4'hF};
        @(posedge clk) mreq.valid <= 1'b0;
        @(negedge clk);
        a = mack;
        r = mrd;
    endtask

    task automatic cfg(input logic w, input logic [31:0] d);
        @(posedge clk) creq <= '{1'b1, w, 8'h10, d};
        @(posedge clk) creq.valid <= 1'b0;
        @(negedge clk);
        a = cack;
        r = crd;
    endtask

    task automatic mr(input logic [11:0] o);
        mem(1'b0, BASE | {20'h0, o}, 32'h0);
    endtask

    task automatic mw(input logic [11:0] o, input logic [31:0] d);
        mem(1'b1, BASE | {20'h0, o}, d);
    endtask

    task automatic setbar();
        cfg(1'b1, BASE);
        cfg(1'b0, 32'h0);
        chk(r, BASE);
        chk({31'h0, a}, 32'h1);
    endtask

    function automatic logic opens();
        return |(ev[3:0] & {en[3], {2{en[2] & en[1]}}, en[0]});
    endfunction

    task automatic chkev();
        mr(12'h000);
        chk(r, ev);
        chk({31'h0, irq}, {31'h0, opens()});
    endtask

    task automatic settle();
        repeat (10) @(posedge clk);
    endtask

    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        conclude();
    end

    // ------------------------------
    // test sequence
    // ------------------------------
    initial begin
        {rst, hrst_n, pme, powered, cardbus, probe, ins, sts} = 8'hC0;
        creq = '0;
        mreq = '0;
        lfsr = 16'h0045;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        mem(1'b0, BASE | 32'h8, 32'h0);
        chk({31'h0, a}, 32'h0);
        setbar();
        mem(1'b0, 32'h0002_0008, 32'h0);
        chk({31'h0, a}, 32'h0);
        for (int o = 0; o < 24; o += 4) begin
            mr(12'(o));
            chk(r, o == 8 ? 32'h3000_0006 : 32'h0);
        end
        $display("test map done");
        @(posedge clk) ins <= 1'b1;
        settle();
        ev = 6;
        chkev();
        mr(12'h008);
        chk(r, 32'h3000_0010);
        mw(12'h004, 32'h6);
        en = 6;
        chkev();
        mw(12'h000, 32'h0);
        chkev();
        for (int b = 2; b <= 4; b += 2) begin
            mw(12'h000, 32'(b));
            ev &= ~b;
            chkev();
        end
        for (int m = 0; m <= 6; m += 6) begin
            mw(12'h004, 32'(m));
            en = m;
            mw(12'h00C, 32'h2);
            ev |= 2;
            chkev();
        end
        mw(12'h000, 32'h2);
        ev = 0;
        $display("test detect done");
        mw(12'h004, 32'h1);
        en = 1;
        for (int cb = 0; cb < 2; cb++) begin
            @(posedge clk) cardbus <= 1'(cb);
            for (int k = 0; k < 4; k++) begin
                @(posedge clk) sts <= ~sts;
                settle();
                if (cb == 0 || sts) ev |= 1;
                chkev();
                mw(12'h000, 32'h1);
                ev = 0;
            end
        end
        $display("test status line done");
        mw(12'h004, 32'h8);
        en = 8;
        @(posedge clk) powered <= 1'b1;
        settle();
        ev = 8;
        chkev();
        mr(12'h008);
        chk(r, 32'h3000_0028);
        mw(12'h00C, 32'hFFFF_FFFF);
        ev = 15;
        mw(12'h004, 32'hFFFF_FFF9);
        en = 9;
        mr(12'h004);
        chk(r, 32'h9);
        chkev();
        $display("test power done");
        repeat (8) begin
            lfsr = nxt(lfsr);
            mw(12'h00C, {16'h0, lfsr});
            ev |= lfsr[3:0];
            en = {lfsr[7], lfsr[6], lfsr[6], lfsr[4]};
            mw(12'h004, 32'(en));
            chkev();
            mw(12'h000, {28'h0, lfsr[11:8]});
            ev &= ~lfsr[11:8];
            chkev();
        end
        $display("test random done");
        @(posedge clk) powered <= 1'b0;
        settle();
        mw(12'h000, 32'hF);
        mw(12'h00C, 32'h1);
        ev = 7;
        @(posedge clk) {pme, hrst_n} <= 2'h2;
        settle();
        mem(1'b0, BASE | 32'h8, 32'h0);
        chk({31'h0, a}, 32'h0);
        @(posedge clk) hrst_n <= 1'b1;
        settle();
        setbar();
        chkev();
        @(posedge clk) {pme, hrst_n} <= 2'h0;
        settle();
        @(posedge clk) hrst_n <= 1'b1;
        settle();
        setbar();
        {ev, en} = {32'd6, 32'd0};
        chkev();
        mr(12'h004);
        chk(r, 32'h0);
        $display("test host reset done");
        mw(12'h000, 32'hF);
        ev = 0;
        @(posedge clk) {probe, ins} <= 2'h2;
        settle();
        chkev();
        @(posedge clk) probe <= 1'b0;
        settle();
        ev = 6;
        chkev();
        $display("test probe done");
        conclude();
    end
endmodule

bind cse_socket_events cse_socket_events_chk i_chk (.CLK, .RST,
    .HOST_BUS_RESET_PIN_N, .PME_ENABLE, .CFG_REQ, .CFG_RDATA, .CFG_ACK,
    .MEM_REQ, .MEM_RDATA, .MEM_ACK, .CARD_PINS, .SOCKET_POWERED,
    .CARDBUS_CARD, .CARD_INTERROGATION, .STATUS_CHANGE_INTERRUPT);

`default_nettype wire
